// ---- shared/rdc_consts.svh ----
// register offsets, field positions and timing figures of the recombiner delay control
`ifndef RDC_CONSTS_SVH
`define RDC_CONSTS_SVH
// register offsets (byte addresses, one word each)
`define RDC_OFS_RECOMB 8'h00
`define RDC_OFS_DELTA 8'h20
`define RDC_OFS_INCDEC 8'h30
`define RDC_OFS_MAXOP 8'h40
`define RDC_OFS_FCJOIN 8'h50
`define RDC_OFS_ENSTAT 8'h54
`define RDC_OFS_LIMSTAT 8'h58
`define RDC_OFS_DELAY 8'h60
// region masks used by the address decode
`define RDC_MASK_LINK 8'hE0
`define RDC_MASK_GRP 8'hF0
`define RDC_MASK_WORD 8'hFF
// per-link recombiner register fields
`define RDC_RB_GRP_LO 0
`define RDC_RB_GRP_HI 1
`define RDC_RB_INCL 2
// increment/decrement control fields
`define RDC_ID_INC 0
`define RDC_ID_DEC 1
`define RDC_ID_DLYD 2
// delay field width in bits, and delay figures in cells
`define RDC_DELAY_W 14
`define RDC_MIN_DELAY 14'h0004
`define RDC_MAXOP_RST 14'h0004
`define RDC_DELTA_RST 8'h04
// one cell time and the system clock period
`define RDC_CELL_TIME_NS 221000
`define RDC_CLK_PERIOD_NS 20
`endif

// ---- shared/rdc_pkg.sv ----
// types shared by the recombiner delay control modules
package rdc_pkg;
    typedef enum logic [1:0] {
        RDC_IDLE,
        RDC_INC_HOLD,
        RDC_DEC_DROP
    } rdc_state_t;
    typedef logic [13:0] rdc_delay_t;
endpackage

// ---- src/rdc_ctrl.sv ----
// receive recombiner delay control: register slave, link join logic and per-group sequencers
`timescale 1ns/1ps
`include "rdc_consts.svh"
module rdc_ctrl #(
    parameter int NUM_LINKS = 8,
    parameter int NUM_GRPS = 4,
    parameter int DELTA_W = 8,
    parameter int CELL_CYCLES = `RDC_CELL_TIME_NS / `RDC_CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire rdc_pkg::rdc_delay_t link_delay [NUM_LINKS],
    input wire logic [NUM_LINKS-1:0] link_user_cell,
    output logic [NUM_LINKS-1:0] link_recomb,
    output logic [NUM_GRPS-1:0] grp_rd_en,
    output logic [NUM_GRPS-1:0] grp_drop
);
    import rdc_pkg::*;

    localparam int CW = $clog2(CELL_CYCLES);
    localparam int LW = $clog2(NUM_LINKS);
    localparam int GW = $clog2(NUM_GRPS);

    // the address map and group field have room for eight links and four groups only
    if (NUM_LINKS != 8 || NUM_GRPS != 4 || DELTA_W < 1 || DELTA_W > 14 || CELL_CYCLES < 2) begin : g_bad_cfg
        $error("rdc_ctrl: unsupported parameter values");
    end

    // register state
    logic [2:0] recomb_r [NUM_LINKS];
    logic [DELTA_W-1:0] delta_r [NUM_GRPS];
    logic [13:0] maxop_r [NUM_GRPS];
    logic [NUM_GRPS-1:0] dlyd_r;
    logic [NUM_LINKS-1:0] fc_r;
    logic [NUM_LINKS-1:0] joined_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [CW-1:0] tick_cnt_r;
    logic cell_tick_r;

    // group sequencer status
    logic [NUM_GRPS-1:0] inc_busy;
    logic [NUM_GRPS-1:0] dec_busy;
    logic [NUM_GRPS-1:0] halt;

    // bus handshake: every access waits exactly one cycle
    wire req = avs_read || avs_write;
    wire wr_go = avs_write && !ack_r;
    assign avs_waitrequest = req && !ack_r;
    assign avs_readdata = rdata_r;

    // address decode
    wire [LW-1:0] lidx = avs_address[LW+1:2];
    wire [GW-1:0] gidx = avs_address[GW+1:2];
    wire sel_recomb = (avs_address & `RDC_MASK_LINK) == `RDC_OFS_RECOMB;
    wire sel_delay = (avs_address & `RDC_MASK_LINK) == `RDC_OFS_DELAY;
    wire sel_delta = (avs_address & `RDC_MASK_GRP) == `RDC_OFS_DELTA;
    wire sel_incdec = (avs_address & `RDC_MASK_GRP) == `RDC_OFS_INCDEC;
    wire sel_maxop = (avs_address & `RDC_MASK_GRP) == `RDC_OFS_MAXOP;
    wire sel_fcjoin = (avs_address & `RDC_MASK_WORD) == `RDC_OFS_FCJOIN;
    wire sel_enstat = (avs_address & `RDC_MASK_WORD) == `RDC_OFS_ENSTAT;
    wire sel_limstat = (avs_address & `RDC_MASK_WORD) == `RDC_OFS_LIMSTAT;

    // byte-enable merge for the low two lanes, the only ones holding fields
    wire [15:0] bmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [15:0] wd16 = avs_writedata[15:0];
    wire [7:0] wd8 = avs_writedata[7:0];
    wire lane0 = avs_byteenable[0];

    // per-link delay evaluation
    logic [13:0] rep_delay [NUM_LINKS];
    logic [NUM_LINKS-1:0] neg;
    logic [NUM_LINKS-1:0] ok4;
    logic [NUM_LINKS-1:0] over;
    logic [NUM_LINKS-1:0] incl;
    logic [GW-1:0] lgrp [NUM_LINKS];

    for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
        assign incl[l] = recomb_r[l][`RDC_RB_INCL];
        assign lgrp[l] = recomb_r[l][`RDC_RB_GRP_HI:`RDC_RB_GRP_LO];
        assign neg[l] = link_delay[l][`RDC_DELAY_W-1];
        // negative values read back with both top bits forced high
        assign rep_delay[l] = neg[l] ? {2'b11, link_delay[l][`RDC_DELAY_W-3:0]} : link_delay[l];
        assign ok4[l] = !neg[l] && (link_delay[l] >= `RDC_MIN_DELAY);
        assign over[l] = !neg[l] && (link_delay[l] > maxop_r[lgrp[l]]);
        assign link_recomb[l] = joined_r[l];

        // joining: at once, or held back until the first user cell when that option is on
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                joined_r[l] <= 1'b0;
            end else if (!incl[l]) begin
                joined_r[l] <= 1'b0;
            end else if (!fc_r[l] || link_user_cell[l]) begin
                joined_r[l] <= 1'b1;
            end
        end
    end

    // per-group aggregation and sequencers
    for (genvar g = 0; g < NUM_GRPS; g++) begin : g_grp
        logic [NUM_LINKS-1:0] member;
        logic [NUM_LINKS-1:0] active;
        logic inc_req;
        logic dec_req;

        for (genvar l = 0; l < NUM_LINKS; l++) begin : g_mem
            assign member[l] = incl[l] && (lgrp[l] == GW'(g));
            assign active[l] = joined_r[l] && (lgrp[l] == GW'(g));
        end

        // a command write is taken only when the group is not already busy
        wire wr_here = wr_go && sel_incdec && lane0 && (gidx == GW'(g)) && !inc_busy[g] && !dec_busy[g];
        assign inc_req = wr_here && wd8[`RDC_ID_INC];
        assign dec_req = wr_here && !wd8[`RDC_ID_INC] && wd8[`RDC_ID_DEC];

        rdc_grp #(
            .DELTA_W(DELTA_W)
        ) u_grp (
            .sys_clk(sys_clk),
            .rst(rst),
            .cell_tick(cell_tick_r),
            .inc_req(inc_req),
            .dec_req(dec_req),
            // the mode bit travels with the command, so a first delayed decrease is not run at once
            .dec_delayed(wd8[`RDC_ID_DLYD]),
            .delta(delta_r[g]),
            .neg_any(|(member & neg)),
            .all_ok4((member & ok4) == member),
            .inc_busy(inc_busy[g]),
            .dec_busy(dec_busy[g]),
            .halt(halt[g]),
            .drop_cell(grp_drop[g])
        );

        // reads stop while halted; cell writes into the buffers are never gated here
        assign grp_rd_en[g] = (|active) && !halt[g];
    end

    // cell-time enable divider
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_cnt_r <= '0;
            cell_tick_r <= 1'b0;
        end else begin
            cell_tick_r <= (tick_cnt_r == CW'(CELL_CYCLES - 1));
            tick_cnt_r <= (tick_cnt_r == CW'(CELL_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
        end
    end

    // link configuration registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                recomb_r[i] <= '0;
            end
            fc_r <= '0;
        end else if (wr_go && lane0) begin
            if (sel_recomb) begin
                recomb_r[lidx] <= wd8[`RDC_RB_INCL:`RDC_RB_GRP_LO];
            end
            if (sel_fcjoin) begin
                fc_r <= wd8[NUM_LINKS-1:0];
            end
        end
    end

    // group configuration registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_GRPS; i++) begin
                delta_r[i] <= DELTA_W'(`RDC_DELTA_RST);
                maxop_r[i] <= `RDC_MAXOP_RST;
            end
            dlyd_r <= '0;
        end else if (wr_go) begin
            if (sel_delta && lane0) begin
                delta_r[gidx] <= wd16[DELTA_W-1:0];
            end
            if (sel_maxop) begin
                maxop_r[gidx] <= (maxop_r[gidx] & ~bmask[13:0]) | (wd16[13:0] & bmask[13:0]);
            end
            if (sel_incdec && lane0) begin
                dlyd_r[gidx] <= wd8[`RDC_ID_DLYD];
            end
        end
    end

    // read data selection; unmapped addresses read zero
    wire [31:0] rd_mux =
        sel_recomb ? {29'h0000_0000, recomb_r[lidx]} :
        sel_delay ? {18'h0_0000, rep_delay[lidx]} :
        sel_delta ? {{(32 - DELTA_W){1'b0}}, delta_r[gidx]} :
        sel_incdec ? {29'h0000_0000, dlyd_r[gidx], dec_busy[gidx], inc_busy[gidx]} :
        sel_maxop ? {18'h0_0000, maxop_r[gidx]} :
        sel_fcjoin ? {24'h00_0000, fc_r} :
        sel_enstat ? {24'h00_0000, joined_r} :
        sel_limstat ? {16'h0000, neg, over} :
        32'h0000_0000;

    // handshake and read data registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= req && !ack_r;
            if (avs_read && !ack_r) begin
                rdata_r <= rd_mux;
            end
        end
    end
endmodule // rdc_ctrl

// ---- src/rdc_grp.sv ----
// per-group delay increase/decrease sequencer with suspension on negative delay
`timescale 1ns/1ps
`include "rdc_consts.svh"
module rdc_grp #(
    parameter int DELTA_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cell_tick,
    input wire logic inc_req,
    input wire logic dec_req,
    input wire logic dec_delayed,
    input wire logic [DELTA_W-1:0] delta,
    input wire logic neg_any,
    input wire logic all_ok4,
    output logic inc_busy,
    output logic dec_busy,
    output logic halt,
    output logic drop_cell
);
    import rdc_pkg::*;

    // the counter is loaded straight from the delta field of at most fourteen bits
    if (DELTA_W < 1 || DELTA_W > 14) begin : g_bad_cfg
        $error("rdc_grp: unsupported delta width");
    end

    rdc_state_t st_r;
    logic [DELTA_W-1:0] cnt_r;
    logic dly_r;
    logic susp_r;
    logic drop_r;

    wire cnt_zero = (cnt_r == '0);
    // delayed mode spreads the drops over cell times to soften the gap seen downstream
    wire drop_now = (st_r == RDC_DEC_DROP) && !cnt_zero && (!dly_r || cell_tick);

    // command sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= RDC_IDLE;
            cnt_r <= '0;
            dly_r <= 1'b0;
            drop_r <= 1'b0;
        end else begin
            drop_r <= drop_now;
            case (st_r)
                RDC_IDLE: begin
                    if (inc_req) begin
                        st_r <= RDC_INC_HOLD;
                        cnt_r <= delta;
                    end else if (dec_req) begin
                        st_r <= RDC_DEC_DROP;
                        cnt_r <= delta;
                        dly_r <= dec_delayed;
                    end
                end
                RDC_INC_HOLD: begin
                    if (cnt_zero) begin
                        st_r <= RDC_IDLE;
                    end else if (cell_tick) begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                RDC_DEC_DROP: begin
                    if (cnt_zero) begin
                        st_r <= RDC_IDLE;
                    end else if (drop_now) begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    st_r <= RDC_IDLE;
                end
            endcase
        end
    end

    // suspension holds until every member is back at the minimum; set wins over release
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            susp_r <= 1'b0;
        end else if (neg_any) begin
            susp_r <= 1'b1;
        end else if (all_ok4) begin
            susp_r <= 1'b0;
        end
    end

    assign inc_busy = (st_r == RDC_INC_HOLD);
    assign dec_busy = (st_r == RDC_DEC_DROP);
    assign halt = inc_busy || susp_r;
    assign drop_cell = drop_r;
endmodule // rdc_grp

// ---- verif/rdc_ctrl_assertions.sv ----
// port-level checks of the recombiner delay control
`timescale 1ns/1ps
module rdc_ctrl_checker #(
    parameter int NUM_LINKS = 8,
    parameter int NUM_GRPS = 4,
    parameter int DELTA_W = 8,
    parameter int CELL_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire rdc_pkg::rdc_delay_t link_delay [NUM_LINKS],
    input wire logic [NUM_LINKS-1:0] link_user_cell,
    input wire logic [NUM_LINKS-1:0] link_recomb,
    input wire logic [NUM_GRPS-1:0] grp_rd_en,
    input wire logic [NUM_GRPS-1:0] grp_drop
);
    import rdc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // the DUT takes a write in its wait cycle; wr_ok marks the answer cycle after it
    wire logic wr_ok = avs_write && !avs_waitrequest;
    logic [1:0] g0_r;
    // group of link 0, so a suspension can be tied to the right reader
    always_ff @(posedge sys_clk) begin
        if (rst)
            g0_r <= 2'h0;
        else if (wr_ok && avs_address == 8'h00)
            g0_r <= avs_writedata[1:0];
    end
    sequence s_inc_g0;
        wr_ok && avs_address == 8'h30 && avs_writedata[0];
    endsequence
    sequence s_dec_now_g1;
        wr_ok && avs_address == 8'h34 && avs_writedata[2:0] == 3'h2;
    endsequence
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait cycle on a new request");
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait lasted more than one cycle");
    inc_halt_a: assert property (s_inc_g0 |=> !grp_rd_en[0])
        else $error("group 0 still reading after increase");
    dec_drop_a: assert property (s_dec_now_g1 |-> ##1 grp_drop[1])
        else $error("immediate decrease did not drop");
    neg_halt_a: assert property (link_recomb[0] && link_delay[0][13] |=> !grp_rd_en[g0_r])
        else $error("negative link did not suspend its group");
    neg_show_a: assert property (avs_read && avs_waitrequest && avs_address == 8'h60
        && link_delay[0][13] |=> avs_readdata[13:12] == 2'b11)
        else $error("negative delay not marked");
    leave_now_a: assert property (wr_ok && avs_address == 8'h00 && !avs_writedata[2] |=> !link_recomb[0])
        else $error("link 0 still joined after clear");
    join_cause_a: assert property ($rose(link_recomb[0]) |-> $past(wr_ok) || $past(link_user_cell[0]))
        else $error("link 0 joined without cause");
endmodule // rdc_ctrl_checker
bind rdc_ctrl rdc_ctrl_checker #(.NUM_LINKS(NUM_LINKS), .NUM_GRPS(NUM_GRPS), .DELTA_W(DELTA_W),
    .CELL_CYCLES(CELL_CYCLES)) u_chk (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link_delay(link_delay), .link_user_cell(link_user_cell), .link_recomb(link_recomb),
    .grp_rd_en(grp_rd_en), .grp_drop(grp_drop));

// ---- verif/rdc_far_model.sv ----
// far side: delay measurement, user cell arrivals and the cell reader
`timescale 1ns/1ps
module rdc_far_model #(
    parameter int NUM_LINKS = 8,
    parameter int NUM_GRPS = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [NUM_GRPS-1:0] grp_rd_en,
    input wire logic [NUM_GRPS-1:0] grp_drop,
    output rdc_pkg::rdc_delay_t link_delay [NUM_LINKS],
    output logic [NUM_LINKS-1:0] link_user_cell
);
    import rdc_pkg::*;
    int drops [NUM_GRPS] = '{default: 0};
    int reads [NUM_GRPS] = '{default: 0};
    // the reader only pulls cells while allowed; buffer writes never stall
    always @(posedge sys_clk) begin
        for (int g = 0; g < NUM_GRPS; g++) begin
            if (rst) begin
                drops[g] <= 0;
                reads[g] <= 0;
            end else begin
                drops[g] <= drops[g] + int'(grp_drop[g]);
                reads[g] <= reads[g] + int'(grp_rd_en[g]);
            end
        end
    end
    task automatic set_delay(input int l, input rdc_delay_t v);
        link_delay[l] <= v;
    endtask
    // one-cycle arrival of a user cell
    task automatic user_cell(input int l);
        link_user_cell[l] <= 1'b1;
        @(posedge sys_clk);
        link_user_cell[l] <= 1'b0;
    endtask
    initial begin
        link_user_cell = '0;
        foreach (link_delay[l]) link_delay[l] = 14'h0004;
    end
endmodule // rdc_far_model

// ---- verif/tb_ima_rx_recombiner_delay_ctrl.sv ----
// self-checking bench of the recombiner delay control
`timescale 1ns/1ps
module tb_ima_rx_recombiner_delay_ctrl;
    import rdc_pkg::*;
    localparam int CC = 8;
    logic sys_clk;
    logic rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    rdc_delay_t link_delay [8];
    logic [7:0] link_user_cell;
    logic [7:0] link_recomb;
    logic [3:0] grp_rd_en;
    logic [3:0] grp_drop;
    int failures = 0;
    int total_checks = 0;
    integer seed = 35;
    int delta_m [4] = '{4, 4, 4, 4};
    logic [31:0] rd;
    rdc_ctrl #(.CELL_CYCLES(CC)) DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .link_delay(link_delay), .link_user_cell(link_user_cell), .link_recomb(link_recomb),
        .grp_rd_en(grp_rd_en), .grp_drop(grp_drop));
    rdc_far_model u_far (.sys_clk(sys_clk), .rst(rst), .grp_rd_en(grp_rd_en), .grp_drop(grp_drop),
        .link_delay(link_delay), .link_user_cell(link_user_cell));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus access, held until waitrequest is seen low; one idle edge after
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, e);
    endtask
    // a hang ends the run as a failure
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (int g = 0; g < 4; g++) begin
            rdchk(8'h20 + 8'(4*g), 32'h0000_0004);
            rdchk(8'h40 + 8'(4*g), 32'h0000_0004);
        end
        bus(1'b1, 8'h84, 32'hFFFF_FFFF);
        rdchk(8'h84, 32'h0000_0000);
        // link l joins group l/2, written last as at start-up
        for (int l = 0; l < 8; l++) bus(1'b1, 8'(4*l), 32'(4 + l/2));
        check(32'(link_recomb), 32'h0000_00FF);
        rdchk(8'h54, 32'h0000_00FF);
        check(32'(grp_rd_en), 32'h0000_000F);
        bus(1'b1, 8'h50, 32'h0000_0080);
        bus(1'b1, 8'h1C, 32'h0000_0003);
        bus(1'b1, 8'h1C, 32'h0000_0007);
        check(32'(link_recomb[7]), 32'h0);
        u_far.user_cell(7);
        repeat (2) @(posedge sys_clk);
        check(32'(link_recomb[7]), 32'h1);
        for (int g = 0; g < 4; g++) begin
            int t;
            int dr;
            int rr;
            delta_m[g] = 1 + ($unsigned($random(seed)) % 3);
            bus(1'b1, 8'h20 + 8'(4*g), 32'(delta_m[g]));
            dr = u_far.drops[g];
            bus(1'b1, 8'h30 + 8'(4*g), 32'h0000_0001);
            rr = u_far.reads[g];
            check(32'(grp_rd_en), 32'(4'hF & ~(4'h1 << g)));
            t = 0;
            rd = 32'h1;
            while (rd[0]) begin
                bus(1'b0, 8'h30 + 8'(4*g), 32'h0);
                t++;
            end
            check(32'(3*t + 3 >= (delta_m[g]-1)*CC && 3*t <= delta_m[g]*CC + 6), 32'h1);
            check(32'(grp_rd_en[g]), 32'h1);
            check(32'(u_far.drops[g] - dr), 32'h0);
            // only the few cycles between the end of the hold and the last poll may read cells
            check(32'(u_far.reads[g] - rr <= 4), 32'h1);
        end
        for (int m = 0; m < 2; m++) begin
            int t;
            int dr;
            dr = u_far.drops[1+m];
            bus(1'b1, 8'h34 + 8'(4*m), m ? 32'h6 : 32'h2);
            t = 0;
            rd = 32'h2;
            while (rd[1]) begin
                bus(1'b0, 8'h34 + 8'(4*m), 32'h0);
                t++;
            end
            repeat (2) @(posedge sys_clk);
            check(32'(u_far.drops[1+m] - dr), 32'(delta_m[1+m]));
            if (m == 1) check(32'(3*t + 3 >= (delta_m[2]-1)*CC), 32'h1);
        end
        u_far.set_delay(0, 14'h2005);
        u_far.set_delay(2, 14'h0010);
        repeat (3) @(posedge sys_clk);
        check(32'(grp_rd_en[0]), 32'h0);
        rdchk(8'h60, 32'h0000_3005);
        bus(1'b0, 8'h58, 32'h0);
        check(rd & 32'h0000_0104, 32'h0000_0104);
        u_far.set_delay(0, 14'h0003);
        repeat (3) @(posedge sys_clk);
        check(32'(grp_rd_en[0]), 32'h0);
        u_far.set_delay(0, 14'h0004);
        repeat (3) @(posedge sys_clk);
        check(32'(grp_rd_en[0]), 32'h1);
        bus(1'b1, 8'h04, 32'h0000_0000);
        check(32'({link_recomb[1], grp_rd_en[0]}), 32'h1);
        for (int l = 0; l < 8; l++) bus(1'b1, 8'(4*l), 32'(l/2));
        rdchk(8'h54, 32'h0000_0000);
        check(32'(grp_rd_en), 32'h0);
        complete_run();
    end
endmodule // tb_ima_rx_recombiner_delay_ctrl
